// ===== hdl/fbps_map.vh
// Constants for the buffered-program flash host controller.
// Assumes it is included by its bare name from the design files.
`ifndef FBPS_MAP_VH
`define FBPS_MAP_VH

// ****
// Register word indices (byte offset = index * 4) and opcodes
// ****
`define FBPS_REG_CTRL 3'h0
`define FBPS_REG_ADDR 3'h1
`define FBPS_REG_DATA 3'h2
`define FBPS_REG_COUNT 3'h3
`define FBPS_REG_BUF 3'h4
`define FBPS_REG_STATUS 3'h5
`define FBPS_REG_RDATA 3'h6

`define FBPS_OP_READ 4'h0
`define FBPS_OP_BUFPROG 4'h1
`define FBPS_OP_PSUSP 4'h2
`define FBPS_OP_PRESUME 4'h3
`define FBPS_OP_ERESUME 4'h4
`define FBPS_OP_ESUSP 4'h5
`define FBPS_OP_ASEL 4'h6
`define FBPS_OP_RESET 4'h7
`define FBPS_OP_ABORTRST 4'h8
`define FBPS_OP_ACCEL 4'h9
`define FBPS_OP_HVREAD 4'hA
`define FBPS_OP_HVOFF 4'hB

// ****
// Flash commands, status bit positions and limits
// ****
`define FBPS_CMD_LOAD 16'h0025
`define FBPS_CMD_CONFIRM 16'h0029
`define FBPS_CMD_ASEL 16'h0090
`define FBPS_CMD_RESET 16'h00F0
`define FBPS_CMD_SUSPEND 16'h00B0
`define FBPS_CMD_RESUME 16'h0030
`define FBPS_CMD_PROGRAM 16'h00A0
`define FBPS_UNLOCK1_ADDR 22'h000555
`define FBPS_UNLOCK1_DATA 16'h00AA
`define FBPS_UNLOCK2_ADDR 22'h0002AA
`define FBPS_UNLOCK2_DATA 16'h0055

`define FBPS_ST_BUSY 0
`define FBPS_ST_REFUSED 1
`define FBPS_ST_ABORT 2
`define FBPS_ST_TIMEOUT 3
`define FBPS_ST_SUSP 4
`define FBPS_ST_ASEL 5
`define FBPS_ST_IDHV 6
`define FBPS_ST_ACCHV 7
`define FBPS_ST_GUARD 8
`define FBPS_ST_RESUMED 9
`define FBPS_ST_READY 10

`define FBPS_DQ_TOGGLE 6
`define FBPS_DQ_TLIMIT 5
`define FBPS_DQ_ABORT 1
`define FBPS_ID_MASK 22'h00004F
`define FBPS_ID_SEC_SET 22'h000003
`define FBPS_ID_PROT_LOW 12'h002
`define FBPS_SECT_LSB 12
`define FBPS_BUF_WORDS 16
`define FBPS_ACCEL_MAX 4'hA

// ****
// Timing: clock rate, guard times and bus phases
// ****
`define FBPS_CLK_MHZ 10
`define FBPS_ERS_GUARD_US 400
`define FBPS_PRG_GUARD_US 5
`define FBPS_ERS_GUARD_CYC (`FBPS_ERS_GUARD_US * `FBPS_CLK_MHZ)
`define FBPS_PRG_GUARD_CYC (`FBPS_PRG_GUARD_US * `FBPS_CLK_MHZ)
`define FBPS_PH_ADDR 3'h1
`define FBPS_PH_STROBE 3'h2
`define FBPS_PH_RELEASE 3'h5
`define FBPS_PH_END 3'h6

`endif

// ===== hdl/fbps_buf_mem.v
// Write buffer memory: one write port, registered read data.
// Assumes a single clock shared with the controller.
`timescale 1ns/100ps

module fbps_buf_mem #(
   parameter DATA_W = 20,
   parameter DEPTH = 16,
   parameter ADDR_W = 4
) (
   // Clock
   input wire clock,
   // Write port
   input wire wrEn,
   input wire [ADDR_W-1:0] wrAddr,
   input wire [DATA_W-1:0] wrData,
   // Read port
   input wire [ADDR_W-1:0] rdAddr,
   output reg [DATA_W-1:0] rdData
);

   reg [DATA_W-1:0] mem [0:DEPTH-1];

   // Store on write, read through a register
   always @(posedge clock) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end

endmodule // fbps_buf_mem

// ===== hdl/fbps_host_ctrl.v
// Host controller driving a parallel NOR flash through its pins.
// Assumes software on Avalon-MM and a flash on the pins below.
//
// What this block does
// - Wait 400 us from erase resume to suspend
// - Resume and see toggling before new program; the code needs only the resume, and toggling just sets the resumed status bit
// - Wait 5 us from program resume to suspend
// - Unlocks, load 25h, then count minus one
// - Data pairs stay within one A21:4 page
// - Confirm with 29h at same sector address
// - After abort send abort reset to recover
// - Accelerated program skips unlocks; ten in a row per sector
// - High voltage, low bits read manufacturer code
`timescale 1ns/100ps
`include "fbps_map.vh"

module fbps_host_ctrl #(
   parameter ADDR_W = 22,
   parameter DATA_W = 16,
   parameter BUF_AW = 4
) (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Avalon-MM slave
   input wire [2:0] avsAddress,
   input wire avsRead,
   input wire avsWrite,
   input wire [31:0] avsWritedata,
   output reg [31:0] avsReaddata,
   output wire avsWaitrequest,
   // Flash bus pins
   output reg [ADDR_W-1:0] flashAddr,
   input wire [DATA_W-1:0] flashDqIn,
   output reg [DATA_W-1:0] flashDqOut,
   output reg flashDqOe,
   output reg flashCeN,
   output reg flashWeN,
   output reg flashOeN,
   input wire readyBusyNPin,
   // High voltage enables
   output reg writeProtectAcceleratePinHv,
   output reg identificationAddressPinHv
);

   localparam S_IDLE = 2'h0;
   localparam S_SEQ = 2'h1;
   localparam S_POLL = 2'h2;
   localparam [11:0] ERS_GUARD = `FBPS_ERS_GUARD_CYC;
   localparam [11:0] PRG_GUARD = `FBPS_PRG_GUARD_CYC;
   localparam [4:0] BUF_MAX = `FBPS_BUF_WORDS;

   // ****
   // Functions
   // ****
   // Program-type commands that end in a busy poll
   function isProgram;
      input [3:0] op;
      begin
         isProgram = (op == `FBPS_OP_BUFPROG) || (op == `FBPS_OP_ACCEL)
            || (op == `FBPS_OP_PRESUME);
      end
   endfunction

   // Address for a high-voltage identification read
   function [21:0] idAddress;
      input [21:0] a;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: idAddress = a & ~`FBPS_ID_MASK;
            2'h1: idAddress = {a[21:12], `FBPS_ID_PROT_LOW};
            2'h2: idAddress = (a & ~`FBPS_ID_MASK) | `FBPS_ID_SEC_SET;
            default: idAddress = a;
         endcase
      end
   endfunction

   // ****
   // State
   // ****
   reg [1:0] stateQ;
   reg [3:0] cmdQ;
   reg [4:0] stepQ;
   reg [2:0] busPhQ;
   reg opReadQ;
   reg [DATA_W-1:0] dqS1Q, dqS2Q, rdCapQ, firstStatQ, rdDataQ;
   reg rbS1Q, rbS2Q;
   reg pollNQ;
   reg [ADDR_W-1:0] addrQ;
   reg [DATA_W-1:0] dataQ;
   reg [4:0] countQ;
   reg [1:0] idSelQ;
   reg suspendedQ, autoselQ, suspReqQ, resumedQ;
   reg refusedQ, abortErrQ, timeoutErrQ;
   reg [11:0] guardQ;
   reg [9:0] accelSectQ;
   reg [3:0] accelCntQ;
   reg rdAckQ;
   wire [19:0] bufRd;
   wire [4:0] bufIdx = stepQ - 5'h04;
   wire busDone = (busPhQ == `FBPS_PH_END);
   wire toggled = firstStatQ[`FBPS_DQ_TOGGLE] ^ rdCapQ[`FBPS_DQ_TOGGLE];
   wire [3:0] newOp = avsWritedata[3:0];
   wire ctrlWr = avsWrite && (avsAddress == `FBPS_REG_CTRL);
   wire sameSect = (addrQ[21:`FBPS_SECT_LSB] == accelSectQ);
   reg [ADDR_W-1:0] sAddr;
   reg [DATA_W-1:0] sData;
   reg sRead, sLast, cmdOk;

   // Write buffer: {page offset, data} per entry
   fbps_buf_mem #(
      .DATA_W(20),
      .DEPTH(`FBPS_BUF_WORDS),
      .ADDR_W(BUF_AW)
   ) bufMem (
      .clock(clock),
      .wrEn(avsWrite && (avsAddress == `FBPS_REG_BUF)),
      .wrAddr(avsWritedata[23:20]),
      .wrData(avsWritedata[19:0]),
      .rdAddr(bufIdx[3:0]),
      .rdData(bufRd)
   );

   // ****
   // Bus cycle of the current step
   // ****
   always @* begin
      sRead = 1'b0;
      sLast = 1'b0;
      sAddr = addrQ;
      sData = 16'h0000;
      if (stateQ == S_POLL) begin
         sRead = 1'b1;
         sLast = 1'b1;
      end else if (((cmdQ == `FBPS_OP_BUFPROG) || (cmdQ == `FBPS_OP_ASEL)
            || (cmdQ == `FBPS_OP_ABORTRST)) && (stepQ < 5'h02)) begin
         sAddr = stepQ[0] ? `FBPS_UNLOCK2_ADDR : `FBPS_UNLOCK1_ADDR;
         sData = stepQ[0] ? `FBPS_UNLOCK2_DATA : `FBPS_UNLOCK1_DATA;
      end else begin
         case (cmdQ)
            `FBPS_OP_READ: begin
               sRead = 1'b1;
               sLast = 1'b1;
            end
            `FBPS_OP_HVREAD: begin
               sRead = 1'b1;
               sLast = 1'b1;
               sAddr = idAddress(addrQ, idSelQ);
            end
            `FBPS_OP_BUFPROG: begin
               if (stepQ == 5'h02) begin
                  sData = `FBPS_CMD_LOAD;
               end else if (stepQ == 5'h03) begin
                  sData = {11'h000, countQ - 5'h01};
               end else if (stepQ == countQ + 5'h04) begin
                  sData = `FBPS_CMD_CONFIRM;
                  sLast = 1'b1;
               end else begin
                  sAddr = {addrQ[21:4], bufRd[19:16]};
                  sData = bufRd[15:0];
               end
            end
            `FBPS_OP_PSUSP, `FBPS_OP_ESUSP: begin
               sData = `FBPS_CMD_SUSPEND;
               sLast = 1'b1;
            end
            `FBPS_OP_PRESUME, `FBPS_OP_ERESUME: begin
               sData = `FBPS_CMD_RESUME;
               sLast = 1'b1;
            end
            `FBPS_OP_ACCEL: begin
               sData = stepQ[0] ? dataQ : `FBPS_CMD_PROGRAM;
               sLast = stepQ[0];
            end
            `FBPS_OP_ASEL: begin
               sAddr = `FBPS_UNLOCK1_ADDR;
               sData = `FBPS_CMD_ASEL;
               sLast = 1'b1;
            end
            default: begin
               sData = `FBPS_CMD_RESET;
               sLast = 1'b1;
            end
         endcase
      end
   end

   // ****
   // Command legality when idle
   // ****
   always @* begin
      case (newOp)
         `FBPS_OP_BUFPROG: cmdOk = !suspendedQ && !autoselQ
            && (countQ != 5'h00) && (countQ <= BUF_MAX);
         `FBPS_OP_ACCEL: cmdOk = !suspendedQ && !autoselQ
            && !identificationAddressPinHv
            && !(sameSect && (accelCntQ >= `FBPS_ACCEL_MAX));
         `FBPS_OP_PRESUME: cmdOk = suspendedQ;
         `FBPS_OP_ESUSP: cmdOk = (guardQ == 12'h000);
         `FBPS_OP_HVREAD: cmdOk = !writeProtectAcceleratePinHv;
         `FBPS_OP_READ, `FBPS_OP_ERESUME,
         `FBPS_OP_ASEL, `FBPS_OP_RESET, `FBPS_OP_ABORTRST: cmdOk = 1'b1;
         default: cmdOk = 1'b0;
      endcase
   end

   // Register answers one cycle after a read is presented
   assign avsWaitrequest = avsRead && !rdAckQ;

   // ****
   // Sequencer, bus engine and register file
   // ****
   always @(posedge clock) begin
      if (!rst_n) begin
         stateQ <= S_IDLE;
         cmdQ <= `FBPS_OP_READ;
         stepQ <= 5'h00;
         busPhQ <= 3'h0;
         opReadQ <= 1'b0;
         dqS1Q <= 16'h0000;
         dqS2Q <= 16'h0000;
         rdCapQ <= 16'h0000;
         firstStatQ <= 16'h0000;
         rdDataQ <= 16'h0000;
         rbS1Q <= 1'b1; // Idle pin reads ready
         rbS2Q <= 1'b1;
         pollNQ <= 1'b0;
         addrQ <= 22'h000000;
         dataQ <= 16'h0000;
         countQ <= 5'h00;
         idSelQ <= 2'h0;
         suspendedQ <= 1'b0;
         autoselQ <= 1'b0;
         suspReqQ <= 1'b0;
         resumedQ <= 1'b0;
         refusedQ <= 1'b0;
         abortErrQ <= 1'b0;
         timeoutErrQ <= 1'b0;
         guardQ <= 12'h000;
         accelSectQ <= 10'h000;
         accelCntQ <= 4'h0;
         rdAckQ <= 1'b0;
         avsReaddata <= 32'h00000000;
         flashAddr <= 22'h000000;
         flashDqOut <= 16'h0000;
         flashDqOe <= 1'b0;
         flashCeN <= 1'b1;
         flashWeN <= 1'b1;
         flashOeN <= 1'b1;
         writeProtectAcceleratePinHv <= 1'b0;
         identificationAddressPinHv <= 1'b0;
      end else begin
         // Pin synchronisers
         dqS1Q <= flashDqIn;
         dqS2Q <= dqS1Q;
         rbS1Q <= readyBusyNPin;
         rbS2Q <= rbS1Q;
         if (guardQ != 12'h000) begin
            guardQ <= guardQ - 12'h001;
         end
         // Bus engine: address, strobe, release, end
         if (busPhQ != 3'h0) begin
            busPhQ <= busDone ? 3'h0 : busPhQ + 3'h1;
         end else if (stateQ != S_IDLE) begin
            busPhQ <= `FBPS_PH_ADDR;
         end
         if (busPhQ == `FBPS_PH_ADDR) begin
            flashAddr <= sAddr;
            flashDqOut <= sData;
            flashDqOe <= !sRead;
            opReadQ <= sRead;
         end
         if (busPhQ == `FBPS_PH_STROBE) begin
            flashCeN <= 1'b0;
            flashWeN <= opReadQ;
            flashOeN <= !opReadQ;
         end
         if (busPhQ == `FBPS_PH_RELEASE) begin
            flashWeN <= 1'b1;
            flashOeN <= 1'b1;
            if (opReadQ) begin
               rdCapQ <= dqS2Q;
            end
         end
         if (busDone) begin
            flashCeN <= 1'b1;
            flashDqOe <= 1'b0;
         end
         // Step through a command sequence
         if ((stateQ == S_SEQ) && busDone) begin
            if (!sLast) begin
               stepQ <= stepQ + 5'h01;
            end else begin
               stateQ <= (isProgram(cmdQ) || (cmdQ == `FBPS_OP_PSUSP))
                  ? S_POLL : S_IDLE;
               pollNQ <= 1'b0;
               if (cmdQ == `FBPS_OP_PRESUME) begin
                  suspendedQ <= 1'b0;
                  guardQ <= PRG_GUARD;
               end
               if (cmdQ == `FBPS_OP_ERESUME) begin
                  guardQ <= ERS_GUARD;
               end
               if (cmdQ == `FBPS_OP_ASEL) begin
                  autoselQ <= 1'b1;
               end
               if ((cmdQ == `FBPS_OP_RESET) || (cmdQ == `FBPS_OP_ABORTRST)) begin
                  autoselQ <= 1'b0;
               end
               if (opReadQ) begin
                  rdDataQ <= rdCapQ;
               end
            end
         end
         // Two status reads per poll round
         if ((stateQ == S_POLL) && busDone) begin
            pollNQ <= !pollNQ;
            if (!pollNQ) begin
               firstStatQ <= rdCapQ;
            end else if (!toggled && rbS2Q) begin
               stateQ <= S_IDLE;
               suspReqQ <= 1'b0;
               if (cmdQ == `FBPS_OP_PSUSP) begin
                  suspendedQ <= 1'b1;
               end else begin
                  writeProtectAcceleratePinHv <= 1'b0;
               end
            end else if (!rbS2Q && rdCapQ[`FBPS_DQ_ABORT]) begin
               abortErrQ <= 1'b1;
               cmdQ <= `FBPS_OP_ABORTRST;
               stepQ <= 5'h00;
               stateQ <= S_SEQ;
               writeProtectAcceleratePinHv <= 1'b0;
            end else if (!rbS2Q && rdCapQ[`FBPS_DQ_TLIMIT]) begin
               timeoutErrQ <= 1'b1;
               cmdQ <= `FBPS_OP_RESET;
               stepQ <= 5'h00;
               stateQ <= S_SEQ;
               writeProtectAcceleratePinHv <= 1'b0;
            end else begin
               if (cmdQ == `FBPS_OP_PRESUME) begin
                  resumedQ <= 1'b1;
               end
               if (suspReqQ) begin
                  cmdQ <= `FBPS_OP_PSUSP;
                  stepQ <= 5'h00;
                  stateQ <= S_SEQ;
                  suspReqQ <= 1'b0;
               end
            end
         end
         // Register writes
         if (avsWrite) begin
            case (avsAddress)
               `FBPS_REG_ADDR: addrQ <= avsWritedata[21:0];
               `FBPS_REG_DATA: dataQ <= avsWritedata[15:0];
               `FBPS_REG_COUNT: countQ <= avsWritedata[4:0];
               default: ;
            endcase
         end
         // Control writes launch or refuse a command
         if (ctrlWr) begin
            if (newOp == `FBPS_OP_PSUSP) begin
               if ((stateQ == S_POLL) && isProgram(cmdQ)
                     && (guardQ == 12'h000)) begin
                  suspReqQ <= 1'b1;
               end else begin
                  refusedQ <= 1'b1;
               end
            end else if (stateQ != S_IDLE) begin
               refusedQ <= 1'b1;
            end else if (newOp == `FBPS_OP_HVOFF) begin
               identificationAddressPinHv <= 1'b0;
            end else if (!cmdOk) begin
               refusedQ <= 1'b1;
            end else begin
               cmdQ <= newOp;
               stepQ <= 5'h00;
               stateQ <= S_SEQ;
               idSelQ <= avsWritedata[5:4];
               refusedQ <= 1'b0;
               abortErrQ <= 1'b0;
               timeoutErrQ <= 1'b0;
               suspReqQ <= 1'b0;
               if (isProgram(newOp)) begin
                  resumedQ <= 1'b0;
               end
               if (newOp == `FBPS_OP_HVREAD) begin
                  identificationAddressPinHv <= 1'b1;
               end
               if (newOp == `FBPS_OP_ACCEL) begin
                  writeProtectAcceleratePinHv <= 1'b1;
                  accelSectQ <= addrQ[21:`FBPS_SECT_LSB];
                  accelCntQ <= sameSect ? accelCntQ + 4'h1 : 4'h1;
               end
            end
         end
         // Register reads answer one cycle later
         rdAckQ <= avsRead && !rdAckQ;
         if (avsRead && !rdAckQ) begin
            case (avsAddress)
               `FBPS_REG_CTRL: avsReaddata <= {28'h0000000, cmdQ};
               `FBPS_REG_ADDR: avsReaddata <= {10'h000, addrQ};
               `FBPS_REG_DATA: avsReaddata <= {16'h0000, dataQ};
               `FBPS_REG_COUNT: avsReaddata <= {27'h0000000, countQ};
               `FBPS_REG_STATUS: avsReaddata <= {21'h000000, rbS2Q,
                  resumedQ, (guardQ != 12'h000),
                  writeProtectAcceleratePinHv, identificationAddressPinHv,
                  autoselQ, suspendedQ, timeoutErrQ, abortErrQ, refusedQ,
                  (stateQ != S_IDLE)};
               `FBPS_REG_RDATA: avsReaddata <= {16'h0000, rdDataQ};
               default: avsReaddata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // fbps_host_ctrl

// ===== verification/fbps_flash_model.sv
// Behavioural parallel NOR flash on the far side of the host controller.
// Assumes registered strobes from the controller on the same clock.
`timescale 1ns/100ps

module fbps_flash_model #(
   parameter MFR_CODE = 16'h005A // Arbitrary value
) (
   // Clock
   input wire clock,
   // Bus from the host
   input wire ceN,
   input wire weN,
   input wire oeN,
   input wire [21:0] addr,
   input wire [15:0] dqOut,
   input wire idHv,
   // Answers to the host
   output wire [15:0] dqIn,
   output reg rbN
);
   reg [15:0] mem [0:255];
   reg [15:0] rdVal;
   reg [15:0] lastVal = 16'h0000;
   reg [15:0] lastLoad = 16'h0000;
   reg weQ = 1'b1;
   reg oeQ = 1'b1;
   reg tog = 1'b0;
   reg asel = 1'b0;
   integer busy = 0;
   integer left = -2;
   integer i;

   // Erased array, ready at power-up
   initial begin
      rbN = 1'b1;
      for (i = 0; i < 256; i = i + 1) mem[i] = 16'hFFFF;
   end

   // Read value: identification, status while busy, else array
   always @* begin
      if (asel || idHv) begin
         if (addr[1:0] == 2'h3) rdVal = 16'h001A;
         else if (addr[1]) rdVal = {15'h0000, addr[21:12] == 10'h000};
         else rdVal = MFR_CODE;
      end else if (busy > 0) rdVal = {8'h00, ~lastLoad[7], tog, 6'h00};
      else rdVal = mem[addr[7:0]];
   end

   // Released bus shows the inverse of the last driven value
   assign dqIn = (!ceN && !oeN) ? rdVal : ~lastVal;

   // Command decoding at the end of each write strobe
   always @(posedge clock) begin
      weQ <= weN;
      oeQ <= oeN;
      if (!oeN) lastVal <= rdVal;
      if (oeN && !oeQ && busy > 0) tog <= ~tog;
      if (busy > 0) busy <= busy - 1;
      rbN <= (busy <= 1);
      if (weN && !weQ && !ceN) begin
         if (dqOut == 16'h0090) asel <= 1'b1;
         else if (dqOut == 16'h00F0) asel <= 1'b0;
         if (left == -1) left <= dqOut + 1;
         else if (left > 0) begin
            mem[addr[7:0]] <= mem[addr[7:0]] & dqOut;
            lastLoad <= dqOut;
            left <= left - 1;
         end else if (left == 0 && dqOut == 16'h0029) begin
            busy <= 60;
            left <= -2;
         end else if (dqOut == 16'h0025) left <= -1;
      end
   end
endmodule // fbps_flash_model

// ===== verification/fbps_host_ctrl_sva.sv
// Checker for the controller's bus handshake and flash pins.
// Assumes it is bound to fbps_host_ctrl.
`timescale 1ns/100ps

module fbps_host_ctrl_sva #(
   parameter ADDR_W = 22,
   parameter DATA_W = 16
) (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Register bus
   input wire avsRead,
   input wire avsWrite,
   input wire avsWaitrequest,
   // Flash pins
   input wire [ADDR_W-1:0] flashAddr,
   input wire [DATA_W-1:0] flashDqOut,
   input wire flashDqOe,
   input wire flashCeN,
   input wire flashWeN,
   input wire flashOeN,
   input wire readyBusyNPin,
   input wire writeProtectAcceleratePinHv,
   input wire identificationAddressPinHv
);
   reg [DATA_W-1:0] prevData_q;

   // Data of the latest write strobe
   always @(posedge clock) begin
      if (!rst_n) prevData_q <= 16'h0000;
      else if (!flashWeN) prevData_q <= flashDqOut;
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_rd_wait;
      avsRead && avsWaitrequest |=> !avsWaitrequest;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait too long");
   property p_wr_nowait;
      avsWrite |-> !avsWaitrequest;
   endproperty
   a_wr_nowait: assert property (p_wr_nowait) else $error("write waited");
   property p_we_width;
      $fell(flashWeN) |-> !flashWeN [*3] ##1 flashWeN;
   endproperty
   a_we_width: assert property (p_we_width) else $error("bad strobe");
   property p_we_ctl;
      !flashWeN |-> !flashCeN && flashOeN && flashDqOe;
   endproperty
   a_we_ctl: assert property (p_we_ctl) else $error("bad write");
   property p_oe_ctl;
      !flashOeN |-> !flashCeN && !flashDqOe && flashWeN;
   endproperty
   a_oe_ctl: assert property (p_oe_ctl) else $error("bad read");
   property p_we_hold;
      !flashWeN && !$past(flashWeN) |-> $stable(flashAddr) && $stable(flashDqOut);
   endproperty
   a_we_hold: assert property (p_we_hold) else $error("moved");
   property p_load_unl;
      $fell(flashWeN) && flashDqOut == 16'h0025 |-> prevData_q == 16'h0055;
   endproperty
   a_load_unl: assert property (p_load_unl) else $error("no unlock");
   property p_asel_unl;
      $fell(flashWeN) && flashDqOut == 16'h0090 |-> prevData_q == 16'h0055;
   endproperty
   a_asel_unl: assert property (p_asel_unl) else $error("no unlock");
   property p_busy_asel;
      !readyBusyNPin |-> !$rose(identificationAddressPinHv)
         && !($fell(flashWeN) && flashDqOut == 16'h0090);
   endproperty
   a_busy_asel: assert property (p_busy_asel) else $error("id busy");
   property p_hv_excl;
      !(writeProtectAcceleratePinHv && identificationAddressPinHv);
   endproperty
   a_hv_excl: assert property (p_hv_excl) else $error("both hv");
endmodule // fbps_host_ctrl_sva

bind fbps_host_ctrl fbps_host_ctrl_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
   fbps_host_ctrl_sva_inst (.clock(clock), .rst_n(rst_n),
   .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest),
   .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
   .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
   .readyBusyNPin(readyBusyNPin),
   .writeProtectAcceleratePinHv(writeProtectAcceleratePinHv),
   .identificationAddressPinHv(identificationAddressPinHv));

// ===== verification/fbps_host_ctrl_tb_top.sv
// Self-checking bench for the flash host controller.
// Assumes the flash model and the bound checker.
`timescale 1ns/100ps
`include "fbps_map.vh"

module fbps_host_ctrl_tb_top;
   localparam [15:0] MFR = 16'h005A; // Arbitrary value
   reg clock = 1'b0;
   reg rst_n = 1'b0;
   reg [2:0] avsAddress = 3'h0;
   reg avsRead = 1'b0;
   reg avsWrite = 1'b0;
   reg [31:0] avsWritedata = 32'h00000000;
   reg [31:0] rdv;
   wire [31:0] avsReaddata;
   wire avsWaitrequest;
   wire [21:0] flashAddr;
   wire [15:0] flashDqIn;
   wire [15:0] flashDqOut;
   wire flashDqOe, flashCeN, flashWeN, flashOeN, readyBusyNPin, accHv, idHv;
   integer miscompares = 0;
   integer numChecks = 0;
   integer cycles = 0;

   // Design and far-side flash
   fbps_host_ctrl fbps_host_ctrl_inst (.clock(clock), .rst_n(rst_n),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest), .flashAddr(flashAddr),
      .flashDqIn(flashDqIn), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
      .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
      .readyBusyNPin(readyBusyNPin), .writeProtectAcceleratePinHv(accHv),
      .identificationAddressPinHv(idHv));
   fbps_flash_model #(.MFR_CODE(MFR)) fbps_flash_model_inst (.clock(clock),
      .ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN), .addr(flashAddr),
      .dqOut(flashDqOut), .idHv(idHv), .dqIn(flashDqIn), .rbN(readyBusyNPin));

   // Clock and hang guard
   always #50 clock = ~clock;
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         complete_run;
      end
   end

   // Value compare
   task chk(input [8*10:1] what, input [31:0] exp, input [31:0] got);
      begin
         numChecks = numChecks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("FAIL %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // Bus write and read, held until waitrequest is seen low
   task wr(input [2:0] idx, input [31:0] d);
      begin
         avsAddress <= idx;
         avsWritedata <= d;
         avsWrite <= 1'b1;
         @(posedge clock);
         while (avsWaitrequest !== 1'b0) @(posedge clock);
         avsWrite <= 1'b0;
         @(posedge clock);
      end
   endtask
   task rdReg(input [2:0] idx);
      begin
         avsAddress <= idx;
         avsRead <= 1'b1;
         @(posedge clock);
         while (avsWaitrequest !== 1'b0) @(posedge clock);
         rdv = avsReaddata;
         avsRead <= 1'b0;
         @(posedge clock);
      end
   endtask
   // Command and wait for idle
   task op(input [3:0] code, input [1:0] sel);
      begin
         wr(`FBPS_REG_CTRL, {26'h0000000, sel, code});
         rdReg(`FBPS_REG_STATUS);
         while (rdv[`FBPS_ST_BUSY] !== 1'b0) rdReg(`FBPS_REG_STATUS);
      end
   endtask
   task st(input integer b, input v);
      begin
         rdReg(`FBPS_REG_STATUS);
         chk("statusbit", v, rdv[b]);
      end
   endtask
   task chkRd(input [31:0] exp);
      begin
         rdReg(`FBPS_REG_RDATA);
         chk("readdata", exp, rdv);
      end
   endtask

   // Reset values and unmapped word
   task t_reset;
      begin
         rdReg(`FBPS_REG_STATUS);
         chk("status", 32'h00000400, rdv);
         rdReg(3'h7);
         chk("unmapped", 32'h00000000, rdv);
      end
   endtask
   // Two-word buffer program, then reprogram the first word of the range
   task t_bufprog;
      begin
         wr(`FBPS_REG_ADDR, 32'h00000120);
         wr(`FBPS_REG_COUNT, 32'h00000002);
         wr(`FBPS_REG_BUF, 32'h00001234);
         wr(`FBPS_REG_BUF, 32'h001100F3);
         op(`FBPS_OP_BUFPROG, 2'h0);
         rdReg(`FBPS_REG_STATUS);
         chk("status", 32'h00000400, rdv & 32'h0000040F);
         wr(`FBPS_REG_COUNT, 32'h00000001);
         wr(`FBPS_REG_BUF, 32'h0000FF0F);
         op(`FBPS_OP_BUFPROG, 2'h0);
         op(`FBPS_OP_READ, 2'h0);
         chkRd(32'h00001204);
         wr(`FBPS_REG_ADDR, 32'h00000121);
         op(`FBPS_OP_READ, 2'h0);
         chkRd(32'h000000F3);
      end
   endtask
   // Commands that must be refused, and a reset that must be accepted
   task t_refuse;
      begin
         wr(`FBPS_REG_COUNT, 32'h00000000);
         op(`FBPS_OP_BUFPROG, 2'h0);
         st(`FBPS_ST_REFUSED, 1'b1);
         wr(`FBPS_REG_COUNT, 32'h00000011);
         op(`FBPS_OP_BUFPROG, 2'h0);
         st(`FBPS_ST_REFUSED, 1'b1);
         op(`FBPS_OP_PRESUME, 2'h0);
         st(`FBPS_ST_REFUSED, 1'b1);
         op(`FBPS_OP_ERESUME, 2'h0);
         op(`FBPS_OP_ESUSP, 2'h0);
         st(`FBPS_ST_REFUSED, 1'b1);
         op(`FBPS_OP_RESET, 2'h0);
         st(`FBPS_ST_REFUSED, 1'b0);
         op(`FBPS_OP_PSUSP, 2'h0);
         st(`FBPS_ST_REFUSED, 1'b1);
      end
   endtask
   // Automatic select by command
   task t_asel;
      begin
         op(`FBPS_OP_ASEL, 2'h0);
         st(`FBPS_ST_ASEL, 1'b1);
         wr(`FBPS_REG_COUNT, 32'h00000002);
         op(`FBPS_OP_BUFPROG, 2'h0);
         st(`FBPS_ST_REFUSED, 1'b1);
         wr(`FBPS_REG_ADDR, 32'h00000000);
         op(`FBPS_OP_READ, 2'h0);
         chkRd({16'h0000, MFR});
         op(`FBPS_OP_RESET, 2'h0);
         st(`FBPS_ST_ASEL, 1'b0);
      end
   endtask
   // Identification by high voltage
   task t_hvid;
      begin
         op(`FBPS_OP_HVREAD, 2'h0);
         chkRd({16'h0000, MFR});
         st(`FBPS_ST_IDHV, 1'b1);
         op(`FBPS_OP_HVREAD, 2'h1);
         chkRd(32'h00000001);
         wr(`FBPS_REG_ADDR, 32'h00001000);
         op(`FBPS_OP_HVREAD, 2'h1);
         chkRd(32'h00000000);
         op(`FBPS_OP_HVREAD, 2'h2);
         chkRd(32'h0000001A);
         op(`FBPS_OP_HVOFF, 2'h0);
         st(`FBPS_ST_IDHV, 1'b0);
      end
   endtask

   // Verdict
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", numChecks, miscompares);
         if (miscompares == 0 && numChecks > 0) begin
            $display("NO MISMATCHES");
         end else begin
            $display("MISMATCHES SEEN");
         end
         $finish;
      end
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_reset;
      t_bufprog;
      t_refuse;
      t_asel;
      t_hvid;
      complete_run;
   end
endmodule // fbps_host_ctrl_tb_top
